// ===== inc/cmp_skip_params.svh
// Purpose: constants for the compare-and-skip execute unit
// Assumes: 16-bit program words, 8-bit data
// Notes: compare opcodes sit in the top seven bits of the word, the complement opcode in the top six
`ifndef CMP_SKIP_PARAMS_SVH
`define CMP_SKIP_PARAMS_SVH
`define OPC_HI_POS 15
`define OPC_LO_POS 9
`define OPC_CMP_EQ 7'h31
`define OPC_CMP_GT 7'h32
`define OPC_CMP_LT 7'h30
`define OPC_COMPLEMENT_FILE_REG_HI_POS 15
`define OPC_COMPLEMENT_FILE_REG_LO_POS 10
`define OPC_COMPLEMENT_FILE_REG 6'h07
`define DEST_POS 9
`define BANK_SEL_POS 8
`define ADDR_HI_POS 7
`define INDEXED_LIMIT 8'h5f
`define WORD_RESET 16'h0000
`define DATA_RESET 8'h00
`endif

// ===== inc/cmp_skip_pkg.sv
// Purpose: types for the compare-and-skip execute unit
// Assumes: nothing
// Notes: phase and cycle kinds
package cmp_skip_pkg;
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_e;
    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_SKIP1 = 2'b01,
        ST_SKIP2 = 2'b10
    } state_e;
    typedef struct packed {
        logic rdReq;
        logic wrReq;
        logic wrToWorking;
        logic useBankSel;
        logic indexed;
        logic [7:0] addr;
    } mem_req_s;
endpackage

// ===== rtl/compare_skip_exec.sv
// Purpose: decode and execute of the compare-and-skip and complement ops
// Assumes: instrWord holds the fetched word, latched at Q4; nextTwoWord flags a two-word follower
// Notes: one instruction cycle is four clocks, Q1 to Q4
`timescale 1ns/100ps
`include "cmp_skip_params.svh"
module compare_skip_exec (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] instrWord,
    input wire logic nextTwoWord,
    input wire logic extendedSet,
    input wire logic [7:0] fileData,
    input wire logic [7:0] workingReg,
    output logic [1:0] phase,
    output cmp_skip_pkg::mem_req_s memReq,
    output logic [7:0] writeData,
    output logic nopCycle,
    output logic advancePc,
    output logic decodeStrobe
);
    cmp_skip_pkg::phase_e phase_q, phase_d;
    cmp_skip_pkg::state_e state_q, state_d;
    cmp_skip_pkg::mem_req_s memReq_q, memReq_d;
    logic [7:0] operand_q, writeData_q, writeData_d;
    logic nop_q, nop_d, adv_q, adv_d, dec_q, dec_d, skipTwo_q;
    logic [15:0] word_q;

    function automatic logic is_op(input logic [15:0] w, input logic [6:0] op);
        is_op = (w[`OPC_HI_POS:`OPC_LO_POS] == op);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode of the latched word
    // equal opcode
    wire logic isEq = is_op(word_q, `OPC_CMP_EQ);
    wire logic isGt = is_op(word_q, `OPC_CMP_GT);
    wire logic isLt = is_op(word_q, `OPC_CMP_LT);
    wire logic isCmp = isEq | isGt | isLt;
    wire logic isComf = (word_q[`OPC_COMPLEMENT_FILE_REG_HI_POS:`OPC_COMPLEMENT_FILE_REG_LO_POS] == `OPC_COMPLEMENT_FILE_REG);
    wire logic [7:0] fAddr = word_q[`ADDR_HI_POS:0];
    wire logic bankBit = word_q[`BANK_SEL_POS];
    wire logic useBsr = bankBit;
    wire logic indexed = !bankBit && extendedSet && (fAddr <= `INDEXED_LIMIT);
    // unsigned subtract, only borrow and zero are used
    wire logic [8:0] diff = {1'b0, operand_q} - {1'b0, workingReg};
    wire logic equal = (diff[7:0] == 8'h00);
    wire logic less = diff[8];
    wire logic greater = !less && !equal;
    wire logic skipHit = (isEq && equal) || (isGt && greater) || (isLt && less);
    wire logic inExec = (state_q == cmp_skip_pkg::ST_EXEC);
    // next cycle is a skip: no-operation, no decode
    wire logic atQ4 = (phase_q == cmp_skip_pkg::PH_Q4);
    wire logic nextSkip = (state_d != cmp_skip_pkg::ST_EXEC);

    ////////////////////////////////////////////////////////////////////////
    // phase and cycle sequencing
    always_comb begin
        phase_d = cmp_skip_pkg::phase_e'(phase_q + 2'h1);
        state_d = state_q;
        if (phase_q == cmp_skip_pkg::PH_Q4) begin
            case (state_q)
                cmp_skip_pkg::ST_EXEC: begin
                    if (isCmp && skipHit) begin
                        state_d = cmp_skip_pkg::ST_SKIP1;
                    end
                end
                // second idle cycle for a two-word follower
                cmp_skip_pkg::ST_SKIP1: begin
                    state_d = skipTwo_q ? cmp_skip_pkg::ST_SKIP2 : cmp_skip_pkg::ST_EXEC;
                end
                cmp_skip_pkg::ST_SKIP2: begin
                    state_d = cmp_skip_pkg::ST_EXEC;
                end
                default: begin
                    state_d = cmp_skip_pkg::ST_EXEC;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-phase activity
    always_comb begin
        memReq_d = '0;
        writeData_d = writeData_q;
        nop_d = atQ4 ? nextSkip : !inExec;
        adv_d = 1'b0;
        dec_d = 1'b0;
        // skip cycles make no memory request in any phase, but still pulse the pc advance
        if (inExec) begin
            memReq_d.addr = fAddr;
            memReq_d.useBankSel = useBsr;
            memReq_d.indexed = indexed;
            memReq_d.rdReq = (phase_q == cmp_skip_pkg::PH_Q1) && (isCmp || isComf);
            if (isComf && phase_q == cmp_skip_pkg::PH_Q3) begin
                memReq_d.wrReq = 1'b1;
                memReq_d.wrToWorking = !word_q[`DEST_POS];
                writeData_d = ~operand_q;
            end
        end
        adv_d = (phase_q == cmp_skip_pkg::PH_Q3);
        // decode pulse only when an execute cycle follows
        dec_d = atQ4 && !nextSkip;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= cmp_skip_pkg::PH_Q1;
            state_q <= cmp_skip_pkg::ST_EXEC;
            word_q <= `WORD_RESET;
            operand_q <= `DATA_RESET;
            skipTwo_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            state_q <= state_d;
            if (phase_q == cmp_skip_pkg::PH_Q4 && state_d == cmp_skip_pkg::ST_EXEC) begin
                word_q <= instrWord;
            end
            if (phase_q == cmp_skip_pkg::PH_Q2) begin
                operand_q <= fileData;
            end
            if (phase_q == cmp_skip_pkg::PH_Q4 && inExec) begin
                skipTwo_q <= nextTwoWord;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            memReq_q <= '0;
            writeData_q <= `DATA_RESET;
            nop_q <= 1'b0;
            adv_q <= 1'b0;
            dec_q <= 1'b0;
        end else begin
            memReq_q <= memReq_d;
            writeData_q <= writeData_d;
            nop_q <= nop_d;
            adv_q <= adv_d;
            dec_q <= dec_d;
        end
    end

    assign phase = phase_q;
    assign memReq = memReq_q;
    assign writeData = writeData_q;
    assign nopCycle = nop_q;
    assign advancePc = adv_q;
    assign decodeStrobe = dec_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_skip_entry: assert property (
        (phase_q == cmp_skip_pkg::PH_Q4 && inExec && isCmp && skipHit)
        |=> state_q == cmp_skip_pkg::ST_SKIP1)
        else $error("skip not entered");
    a_no_skip: assert property (
        (phase_q == cmp_skip_pkg::PH_Q4 && inExec && !(isCmp && skipHit))
        |=> state_q == cmp_skip_pkg::ST_EXEC)
        else $error("spurious skip");
    a_two_word: assert property (
        (phase_q == cmp_skip_pkg::PH_Q4 && state_q == cmp_skip_pkg::ST_SKIP1 && skipTwo_q)
        |=> state_q == cmp_skip_pkg::ST_SKIP2 [*4] ##1 state_q == cmp_skip_pkg::ST_EXEC)
        else $error("two-word skip wrong length");
    a_skip_idle: assert property (
        !inExec |-> !memReq_q.rdReq && !memReq_q.wrReq && nop_q)
        else $error("activity in skip cycle");
    a_cmp_nowrite: assert property (
        isCmp |-> !memReq_d.wrReq)
        else $error("compare wrote");
    a_read_phase: assert property (
        memReq_q.rdReq |-> phase_q == cmp_skip_pkg::PH_Q2)
        else $error("read outside Q2");
    a_complement_file_reg_write: assert property (
        memReq_q.wrReq |-> phase_q == cmp_skip_pkg::PH_Q4 && writeData_q == ~operand_q)
        else $error("complement write wrong");
    a_indexed_addr: assert property (
        memReq_q.indexed |-> !memReq_q.useBankSel && memReq_q.addr <= `INDEXED_LIMIT)
        else $error("indexed mode misapplied");
    a_drop_fetched: assert property (
        (atQ4 && inExec && isCmp && skipHit) |=> $stable(word_q))
        else $error("fetched word not dropped");
    a_decode_pulse: assert property (
        dec_q |-> phase_q == cmp_skip_pkg::PH_Q1 && inExec && !nop_q)
        else $error("decode strobe outside an execute cycle");
    a_nop_span: assert property (
        nop_q == !inExec)
        else $error("no-operation flag misaligned");
    a_pc_advance: assert property (
        adv_q |-> phase_q == cmp_skip_pkg::PH_Q4)
        else $error("pc advance outside Q4");

    // main scenarios
    c_eq_skip: cover property (inExec && isEq && skipHit && phase_q == cmp_skip_pkg::PH_Q4);
    c_gt_skip: cover property (inExec && isGt && skipHit && phase_q == cmp_skip_pkg::PH_Q4);
    c_two_word: cover property (state_q == cmp_skip_pkg::ST_SKIP2);
    c_lt_skip: cover property (inExec && isLt && skipHit && atQ4);
    c_complement_file_reg_write: cover property (memReq_q.wrReq && !memReq_q.wrToWorking);
endmodule

// ===== testbench/testbench.sv
// Purpose: self-checking bench for the compare-and-skip execute unit
// Assumes: opcode constants from the shared header
// Notes: skips are counted as nop clocks between two decode strobes
`timescale 1ns/100ps
`include "cmp_skip_params.svh"
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic nextTwoWord = 1'b0;
    logic extendedSet = 1'b0;
    logic [7:0] fileData = 8'h00;
    logic [7:0] workingReg = 8'h00;
    logic [1:0] phase;
    cmp_skip_pkg::mem_req_s memReq;
    logic [7:0] writeData;
    logic nopCycle;
    logic advancePc;
    logic decodeStrobe;
    int failures = 0;
    int n_compared = 0;
    compare_skip_exec i_dut (.clk(clk), .arst_n(arst_n), .instrWord(instrWord),
        .nextTwoWord(nextTwoWord), .extendedSet(extendedSet), .fileData(fileData),
        .workingReg(workingReg), .phase(phase), .memReq(memReq), .writeData(writeData),
        .nopCycle(nopCycle), .advancePc(advancePc), .decodeStrobe(decodeStrobe));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wait_decode();
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (decodeStrobe === 1'b1) begin
                return;
            end
        end
        failures++;
        $display("MISMATCH %0t decode timeout", $time);
        summarize();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // one instruction, then a filler word; counts clocks up to the next decode
    task automatic run_op(input logic [15:0] word, input logic [7:0] f, input logic [7:0] w,
            input logic two, input logic ext, input int nops);
        int clks;
        int nopClks;
        int wrs;
        int advs;
        logic [8:0] lastWr;
        logic idx;
        logic comp;
        nopClks = 0;
        wrs = 0;
        advs = 0;
        lastWr = 9'h000;
        idx = !word[8] && ext && (word[7:0] <= 8'h5f);
        comp = (word[15:10] == `OPC_COMPLEMENT_FILE_REG);
        @(posedge clk);
        instrWord <= word;
        fileData <= f;
        workingReg <= w;
        nextTwoWord <= two;
        extendedSet <= ext;
        wait_decode();
        chk(phase, 16'h0000, "decode phase");
        @(posedge clk);
        instrWord <= 16'h0000;
        for (clks = 1; clks < 40; clks++) begin
            #1;
            if (decodeStrobe === 1'b1) break;
            if (nopCycle === 1'b1) nopClks++;
            if (advancePc === 1'b1) advs++;
            if (memReq.wrReq === 1'b1) begin
                wrs++;
                lastWr = {memReq.wrToWorking, writeData};
            end
            if (memReq.rdReq === 1'b1) begin
                chk(phase, 16'h0001, "read phase");
                chk({memReq.useBankSel, memReq.indexed, memReq.addr},
                    {word[8], idx, word[7:0]}, "operand");
            end
            @(posedge clk);
        end
        if (clks == 40) begin
            failures++;
            $display("MISMATCH %0t cycle timeout", $time);
            summarize();
        end
        chk(clks, 4 * (1 + nops), "cycle clocks");
        chk(advs, 1 + nops, "pc advances");
        chk(nopClks, 4 * nops, "nop clocks");
        chk(wrs, comp ? 1 : 0, "writes");
        if (comp) chk(lastWr, {~word[9], ~f}, "result");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // equality skip over one-word and two-word followers
    task automatic sc_equal();
        run_op({`OPC_CMP_EQ, 1'b1, 8'h42}, 8'h3c, 8'h3c, 1'b0, 1'b0, 1);
        run_op({`OPC_CMP_EQ, 1'b1, 8'h42}, 8'h3c, 8'h3d, 1'b0, 1'b0, 0);
        run_op({`OPC_CMP_EQ, 1'b1, 8'hff}, 8'h00, 8'h00, 1'b1, 1'b0, 2);
    endtask
    // unsigned boundaries for the greater and less variants
    task automatic sc_order();
        run_op({`OPC_CMP_GT, 1'b1, 8'h10}, 8'h80, 8'h7f, 1'b0, 1'b0, 1);
        run_op({`OPC_CMP_GT, 1'b1, 8'h10}, 8'h7f, 8'h80, 1'b0, 1'b0, 0);
        run_op({`OPC_CMP_GT, 1'b1, 8'h10}, 8'h55, 8'h55, 1'b1, 1'b0, 0);
        run_op({`OPC_CMP_LT, 1'b1, 8'h20}, 8'h00, 8'hff, 1'b1, 1'b0, 2);
        run_op({`OPC_CMP_LT, 1'b1, 8'h20}, 8'hff, 8'h00, 1'b0, 1'b0, 0);
    endtask
    // bank bit and indexed window edges
    task automatic sc_bank();
        run_op({`OPC_CMP_EQ, 1'b0, 8'h5f}, 8'h01, 8'h02, 1'b0, 1'b1, 0);
        run_op({`OPC_CMP_EQ, 1'b0, 8'h60}, 8'h01, 8'h02, 1'b0, 1'b1, 0);
        run_op({`OPC_CMP_EQ, 1'b1, 8'h05}, 8'h01, 8'h02, 1'b0, 1'b1, 0);
        run_op({`OPC_CMP_EQ, 1'b0, 8'h05}, 8'h01, 8'h02, 1'b0, 1'b0, 0);
    endtask
    // complement to working and to file
    task automatic sc_complement_file_reg();
        run_op({`OPC_COMPLEMENT_FILE_REG, 1'b0, 1'b1, 8'h33}, 8'h13, 8'h00, 1'b0, 1'b0, 0);
        run_op({`OPC_COMPLEMENT_FILE_REG, 1'b1, 1'b0, 8'h70}, 8'ha5, 8'h00, 1'b0, 1'b1, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        sc_equal();
        sc_order();
        sc_bank();
        sc_complement_file_reg();
        summarize();
    end
endmodule
